// file: design/spc_device.sv
// device end: serial port into register space and page-buffered eeprom
`timescale 1ns/1ps
module spc_device
    import spc_pkg::*;
#(
    parameter int REG_BYTES     = 64,
    parameter int EE_BYTES      = 256,
    parameter int COMMIT_CYCLES = SPC_COMMIT_CYC
)
(
    spc_if.dev        link,
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    input  wire logic memory_space_select_i,
    output logic      ee_busy_o
);
    localparam int RA = $clog2(REG_BYTES);
    localparam int EA = $clog2(EE_BYTES);
    localparam int TW = $clog2(COMMIT_CYCLES + 1);

    typedef enum {SPC_PH_CMD, SPC_PH_ADDR, SPC_PH_DATA, SPC_PH_STAT, SPC_PH_IGNORE} spc_phase_e;

    // link domain
    spc_phase_e   phase;
    logic [3:0]   cnt;
    logic [15:0]  sr;
    logic [15:0]  sr_next;
    logic [7:0]   cmd;
    logic [15:0]  addr;
    logic         ee_op;
    logic [7:0]   tx_byte;
    logic         wel;
    logic         page_ready;
    logic [EA-SPC_PAGE_AW-1:0] page_base;
    logic         sel_s1;
    logic         sel_s2;
    logic         busy_s1;
    logic         busy_s2;
    logic         frame_rst_n;
    logic         cmd_done;
    logic         addr_done;
    logic         data_done;
    logic         load_page;
    logic         reg_wr;
    logic         ee_wr;
    logic         tx_phase;
    logic [7:0]   status;
    logic [7:0]   reg_mem  [REG_BYTES];
    logic [7:0]   page_buf [SPC_PAGE_BYTES];
    // system domain
    logic [7:0]   ee_mem   [EE_BYTES];
    logic         cs_s1;
    logic         cs_s2;
    logic         cs_s3;
    logic         rdy_s1;
    logic         rdy_s2;
    logic         committed;
    logic         commit;
    logic [TW-1:0] timer;

    // byte fetch from the selected space
    function automatic logic [7:0] mem_byte(input logic sel, input logic [15:0] a);
        if (sel)
            return ee_mem[a[EA-1:0]];
        return reg_mem[a[RA-1:0]];
    endfunction

    // =====================================================
    // link-domain decode
    assign frame_rst_n = rstn_i & ~link.chip_select_low;
    assign sr_next     = {sr[14:0], link.mosi};
    assign cmd_done    = (phase == SPC_PH_CMD)  && (cnt[2:0] == SPC_BIT_LAST);
    assign addr_done   = (phase == SPC_PH_ADDR) && (cnt == SPC_ADDR_LAST);
    assign data_done   = (phase == SPC_PH_DATA) && (cnt[2:0] == SPC_BIT_LAST);
    assign load_page   = addr_done && (cmd == SPC_CMD_WRITE) && sel_s2 && wel;
    assign reg_wr      = data_done && (cmd == SPC_CMD_WRITE) && !ee_op;
    assign ee_wr       = data_done && (cmd == SPC_CMD_WRITE) && ee_op;
    assign tx_phase    = ((phase == SPC_PH_DATA) && (cmd == SPC_CMD_READ)) || (phase == SPC_PH_STAT);
    assign status      = 8'(busy_s2) << SPC_ST_BUSY;

    // =====================================================
    // link-domain synchronisers
    always_ff @(posedge link.sclk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sel_s1  <= 1'b0;
            sel_s2  <= 1'b0;
            busy_s1 <= 1'b0;
            busy_s2 <= 1'b0;
        end
        else
        begin
            sel_s1  <= memory_space_select_i;
            sel_s2  <= sel_s1;
            busy_s1 <= ee_busy_o;
            busy_s2 <= busy_s1;
        end
    end

    // =====================================================
    // frame engine, cleared whenever deselected
    always_ff @(posedge link.sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            phase   <= SPC_PH_CMD;
            cnt     <= 4'h0;
            sr      <= 16'h0000;
            cmd     <= 8'h00;
            addr    <= 16'h0000;
            ee_op   <= 1'b0;
            tx_byte <= 8'h00;
        end
        else
        begin
            sr  <= sr_next;
            cnt <= cnt + 4'h1;
            case (phase)
                SPC_PH_CMD:
                begin
                    if (cmd_done)
                    begin
                        cnt <= 4'h0;
                        cmd <= sr_next[7:0];
                        if (sr_next[7:0] == SPC_CMD_READ || sr_next[7:0] == SPC_CMD_WRITE)
                            phase <= SPC_PH_ADDR;
                        else if (sr_next[7:0] == SPC_CMD_RDSR)
                        begin
                            phase   <= SPC_PH_STAT;
                            tx_byte <= status;
                        end
                        else
                            phase <= SPC_PH_IGNORE;
                    end
                end
                SPC_PH_ADDR:
                begin
                    if (addr_done)
                    begin
                        cnt   <= 4'h0;
                        ee_op <= sel_s2;
                        if (cmd == SPC_CMD_READ)
                        begin
                            tx_byte <= mem_byte(sel_s2, sr_next);
                            addr    <= sr_next + 16'h0001;
                            phase   <= SPC_PH_DATA;
                        end
                        else if (!sel_s2 || wel)
                        begin
                            addr  <= sr_next;
                            phase <= SPC_PH_DATA;
                        end
                        else
                            phase <= SPC_PH_IGNORE;
                    end
                end
                SPC_PH_DATA:
                begin
                    if (data_done)
                    begin
                        cnt <= 4'h0;
                        if (cmd == SPC_CMD_READ)
                        begin
                            tx_byte <= mem_byte(ee_op, addr);
                            addr    <= addr + 16'h0001;
                        end
                        else if (ee_op)
                            addr <= {addr[15:SPC_PAGE_AW], addr[SPC_PAGE_AW-1:0] + 5'h01};
                        else
                            addr <= addr + 16'h0001;
                    end
                end
                SPC_PH_STAT:
                begin
                    if (cnt[2:0] == SPC_BIT_LAST)
                    begin
                        cnt     <= 4'h0;
                        tx_byte <= status;
                    end
                end
                default:
                    cnt <= 4'h0;
            endcase
        end
    end

    // =====================================================
    // serial output, changed on the falling edge
    always_ff @(negedge link.sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            link.miso    <= 1'b0;
            link.miso_oe <= 1'b0;
        end
        else
        begin
            link.miso    <= tx_byte[SPC_BIT_LAST - cnt[2:0]];
            link.miso_oe <= tx_phase;
        end
    end

    // =====================================================
    // register space
    always_ff @(posedge link.sclk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i < REG_BYTES; i++)
                reg_mem[i] <= 8'h00;
        end
        else if (reg_wr)
            reg_mem[addr[RA-1:0]] <= sr_next[7:0];
    end

    // =====================================================
    // page buffer
    always_ff @(posedge link.sclk)
    begin
        if (load_page)
        begin
            for (int i = 0; i < SPC_PAGE_BYTES; i++)
                page_buf[i] <= ee_mem[{sr_next[EA-1:SPC_PAGE_AW], SPC_PAGE_AW'(i)}];
        end
        else if (ee_wr)
            page_buf[addr[SPC_PAGE_AW-1:0]] <= sr_next[7:0];
    end

    // =====================================================
    // write-enable latch and page-ready flag
    always_ff @(posedge link.sclk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wel        <= 1'b0;
            page_ready <= 1'b0;
            page_base  <= '0;
        end
        else
        begin
            if (cmd_done && sr_next[7:0] == SPC_CMD_WREN)
                wel <= 1'b1;
            else if (ee_wr)
                wel <= 1'b0;
            if (ee_wr)
            begin
                page_ready <= 1'b1;
                page_base  <= addr[EA-1:SPC_PAGE_AW];
            end
            // idle clocks while deselected must not drop a pending commit
            else if (frame_rst_n
                     && ((phase == SPC_PH_CMD && cnt == 4'h0) || (phase == SPC_PH_DATA && cnt[2:0] == 3'h0)))
                page_ready <= 1'b0;
        end
    end

    // =====================================================
    // system domain: deselect sense and page commit
    assign commit = cs_s2 && !cs_s3 && rdy_s2 && !committed;

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cs_s1     <= 1'b1;
            cs_s2     <= 1'b1;
            cs_s3     <= 1'b1;
            rdy_s1    <= 1'b0;
            rdy_s2    <= 1'b0;
            committed <= 1'b0;
        end
        else
        begin
            cs_s1     <= link.chip_select_low;
            cs_s2     <= cs_s1;
            cs_s3     <= cs_s2;
            rdy_s1    <= page_ready;
            rdy_s2    <= rdy_s1;
            committed <= rdy_s2 && (committed || commit);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i < EE_BYTES; i++)
                ee_mem[i] <= 8'h00;
        end
        else if (commit)
        begin
            for (int i = 0; i < SPC_PAGE_BYTES; i++)
                ee_mem[{page_base, SPC_PAGE_AW'(i)}] <= page_buf[i];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ee_busy_o <= 1'b0;
            timer     <= '0;
        end
        else if (commit)
        begin
            ee_busy_o <= 1'b1;
            timer     <= TW'(COMMIT_CYCLES - 1);
        end
        else if (ee_busy_o)
        begin
            if (timer == '0)
                ee_busy_o <= 1'b0;
            else
                timer <= timer - TW'(1);
        end
    end
endmodule

// file: design/spc_host.sv
// serial bus master end: makes the link clock and runs one frame per request
`timescale 1ns/1ps
module spc_host
    import spc_pkg::*;
#(
    parameter int HALF_DIV  = SPC_HALF_DIV,
    parameter int SAMPLE_AT = SPC_SAMPLE_AT,
    parameter int CS_GAP    = SPC_CS_GAP
)
(
    spc_if.host              link,
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic [7:0]  req_cmd_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [7:0]  req_len_i,
    input  wire logic [7:0]  wdata_i,
    output logic             wdata_take_o,
    output logic [7:0]       rdata_o,
    output logic             rdata_valid_o
);
    typedef enum {SPC_H_IDLE, SPC_H_LO, SPC_H_HI, SPC_H_END, SPC_H_GAP} spc_host_e;

    spc_host_e   st;
    logic [7:0]  div;
    logic [2:0]  bitn;
    logic [8:0]  idx;
    logic [8:0]  nbytes;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  txb;
    logic [7:0]  rx;
    logic        sclk;
    logic        cs_n;
    logic        miso_s1;
    logic        miso_s2;
    logic [8:0]  nhdr;
    logic        rx_phase;

    // header length and receive phase
    assign nhdr     = (cmd == SPC_CMD_READ || cmd == SPC_CMD_WRITE) ? 9'h003 : 9'h001;
    assign rx_phase = (idx >= nhdr) && (cmd == SPC_CMD_READ || cmd == SPC_CMD_RDSR);

    assign req_ready_o          = (st == SPC_H_IDLE);
    assign link.sclk            = sclk;
    assign link.chip_select_low = cs_n;
    assign link.mosi            = txb[7];
    assign link.mosi_oe         = !cs_n && !rx_phase;

    // =====================================================
    // miso synchroniser
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end
        else
        begin
            miso_s1 <= link.miso;
            miso_s2 <= miso_s1;
        end
    end

    // =====================================================
    // frame sequencer
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st            <= SPC_H_IDLE;
            div           <= 8'h00;
            bitn          <= 3'h0;
            idx           <= 9'h000;
            nbytes        <= 9'h000;
            cmd           <= 8'h00;
            addr          <= 16'h0000;
            txb           <= 8'h00;
            rx            <= 8'h00;
            sclk          <= 1'b0;
            cs_n          <= 1'b1;
            rdata_o       <= 8'h00;
            rdata_valid_o <= 1'b0;
            wdata_take_o  <= 1'b0;
        end
        else
        begin
            rdata_valid_o <= 1'b0;
            wdata_take_o  <= 1'b0;
            div           <= div + 8'h01;
            case (st)
                SPC_H_IDLE:
                begin
                    div <= 8'h00;
                    if (req_valid_i)
                    begin
                        cmd    <= req_cmd_i;
                        addr   <= req_addr_i;
                        txb    <= req_cmd_i;
                        idx    <= 9'h000;
                        bitn   <= 3'h0;
                        nbytes <= ((req_cmd_i == SPC_CMD_READ || req_cmd_i == SPC_CMD_WRITE) ? 9'h003 : 9'h001)
                                  + {1'b0, req_len_i};
                        cs_n   <= 1'b0;
                        st     <= SPC_H_LO;
                    end
                end
                SPC_H_LO:
                begin
                    if (div == 8'(HALF_DIV - 1))
                    begin
                        div  <= 8'h00;
                        sclk <= 1'b1;
                        st   <= SPC_H_HI;
                    end
                end
                SPC_H_HI:
                begin
                    if (div == 8'(SAMPLE_AT))
                        rx <= {rx[6:0], miso_s2};
                    if (div == 8'(HALF_DIV - 1))
                    begin
                        div  <= 8'h00;
                        sclk <= 1'b0;
                        bitn <= bitn + 3'h1;
                        txb  <= {txb[6:0], 1'b0};
                        st   <= SPC_H_LO;
                        if (bitn == SPC_BIT_LAST)
                        begin
                            if (rx_phase)
                            begin
                                // last bit may be sampled on this same edge
                                rdata_o       <= (div == 8'(SAMPLE_AT)) ? {rx[6:0], miso_s2} : rx;
                                rdata_valid_o <= 1'b1;
                            end
                            idx <= idx + 9'h001;
                            if (idx + 9'h001 == nbytes)
                                st <= SPC_H_END;
                            else if (idx == 9'h000 && nhdr == 9'h003)
                                txb <= addr[15:8];
                            else if (idx == 9'h001)
                                txb <= addr[7:0];
                            else if (cmd == SPC_CMD_WRITE)
                            begin
                                txb          <= wdata_i;
                                wdata_take_o <= 1'b1;
                            end
                            else
                                txb <= 8'h00;
                        end
                    end
                end
                SPC_H_END:
                begin
                    if (div == 8'(HALF_DIV - 1))
                    begin
                        div  <= 8'h00;
                        cs_n <= 1'b1;
                        st   <= SPC_H_GAP;
                    end
                end
                SPC_H_GAP:
                begin
                    if (div == 8'(CS_GAP - 1))
                        st <= SPC_H_IDLE;
                end
                default:
                    st <= SPC_H_IDLE;
            endcase
        end
    end
endmodule

// file: design/spc_if.sv
// serial link between master and register/eeprom port
`timescale 1ns/1ps
interface spc_if;
    logic sclk;
    logic chip_select_low;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;

    modport dev
    (
        input  sclk,
        input  chip_select_low,
        input  mosi,
        input  mosi_oe,
        output miso,
        output miso_oe
    );

    modport host
    (
        output sclk,
        output chip_select_low,
        output mosi,
        output mosi_oe,
        input  miso,
        input  miso_oe
    );
endinterface

// file: design/spc_pkg.sv
// shared constants of the serial register/eeprom port
package spc_pkg;
    // command codes
    localparam logic [7:0] SPC_CMD_WREN  = 8'h06;
    localparam logic [7:0] SPC_CMD_WRITE = 8'h02;
    localparam logic [7:0] SPC_CMD_READ  = 8'h03;
    localparam logic [7:0] SPC_CMD_RDSR  = 8'h05;
    // framing
    localparam logic [2:0] SPC_BIT_LAST  = 3'h7;
    localparam logic [3:0] SPC_ADDR_LAST = 4'hF;
    localparam int         SPC_PAGE_BYTES = 32;
    localparam int         SPC_PAGE_AW    = 5;
    localparam int         SPC_ST_BUSY    = 0;
    // page commit time
    localparam int         SPC_COMMIT_MS   = 5;
    localparam int         SPC_SYS_NS      = 8;
    localparam int         SPC_COMMIT_CYC  = (SPC_COMMIT_MS * 1000000) / SPC_SYS_NS;
    // master timing defaults
    localparam int         SPC_HALF_DIV  = 4;
    localparam int         SPC_SAMPLE_AT = 3;
    localparam int         SPC_CS_GAP    = 8;
endpackage

// file: testbench/spc_assertions.sv
// concurrent checks on the serial link between master and device
`timescale 1ns/1ps
module spc_assertions
    import spc_pkg::*;
#(
    parameter int COMMIT = 400
)
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic sclk,
    input wire logic chip_select_low,
    input wire logic mosi,
    input wire logic mosi_oe,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic ee_busy_o
);
    logic [5:0] cnt;
    logic [7:0] cmd;
    int         bcnt;

    // ====================
    // frame position and command as the device sees them
    always_ff @(posedge sclk or posedge chip_select_low or negedge rstn_i)
    begin
        if (!rstn_i || chip_select_low)
        begin
            cnt <= 6'h00;
            cmd <= 8'h00;
        end
        else
        begin
            cnt <= cnt + {5'h00, cnt != 6'h3F};
            if (cnt < 6'h08)
                cmd <= {cmd[6:0], mosi};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i || !ee_busy_o)
            bcnt <= 0;
        else
            bcnt <= bcnt + 1;
    end

    // ====================
    // properties
    AST_IDLE_QUIET: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) chip_select_low |-> !miso_oe)
        else $error("miso driven while deselected");
    AST_HALF_DUPLEX: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) !(miso_oe && mosi_oe))
        else $error("both ends drive data");
    AST_MISO_ON_FALL: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(sclk) && miso_oe |-> $stable(miso))
        else $error("miso moved at rising clock");
    AST_HEADER_QUIET: assert property (@(posedge sclk) disable iff (!rstn_i || chip_select_low)
        cnt < 6'h08 || (cmd == SPC_CMD_READ && cnt < 6'h18) |-> !miso_oe)
        else $error("miso driven inside header");
    AST_STATUS_DRIVE: assert property (@(posedge sclk) disable iff (!rstn_i || chip_select_low)
        cnt == 6'h08 && cmd == SPC_CMD_RDSR |-> miso_oe && !$past(miso_oe))
        else $error("status byte not started after command");
    AST_READ_DRIVE: assert property (@(posedge sclk) disable iff (!rstn_i || chip_select_low)
        cnt == 6'h18 && cmd == SPC_CMD_READ |-> miso_oe && !$past(miso_oe))
        else $error("read data not started after address");
    AST_OTHER_QUIET: assert property (@(posedge sclk) disable iff (!rstn_i || chip_select_low)
        cnt >= 6'h08 && cmd != SPC_CMD_READ && cmd != SPC_CMD_RDSR |-> !miso_oe)
        else $error("miso driven for a non-read command");
    AST_BUSY_DESEL: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(ee_busy_o) |-> chip_select_low)
        else $error("commit started while selected");
    AST_BUSY_LEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $fell(ee_busy_o) |-> bcnt inside {[COMMIT - 1 : COMMIT + 1]})
        else $error("commit length wrong");
endmodule

// file: testbench/tb_spi_slave_register_eeprom_access.sv
// bench: host and device joined, second device driven by hand
`timescale 1ns/1ps
module tb_spi_slave_register_eeprom_access
    import spc_pkg::*;
;
    localparam int COMMIT = 400;
    typedef struct {
        logic        ees;
        logic [15:0] wa;
        logic [7:0]  wl;
        logic [7:0]  base;
        logic [15:0] ra;
        logic [7:0]  rl;
    } spc_row_s;

    logic        clk;
    logic        rstn;
    logic        ees;
    logic        vld;
    logic        rdy;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  len;
    logic [7:0]  wdat;
    logic        take;
    logic [7:0]  rdat;
    logic        rval;
    logic        busy;
    logic        busy2;
    logic [63:0] rx;
    logic [7:0]  wq[$];
    logic [7:0]  rq[$];
    logic [7:0]  regm[64];
    logic [7:0]  eem[256];
    int          wi;
    int          checked;
    int          miscompares;
    spc_row_s    rows[5] = '{'{1'b0, 16'h0000, 8'h01, 8'hA5, 16'h0000, 8'h02},
                             '{1'b0, 16'h003E, 8'h02, 8'h3C, 16'h003D, 8'h03},
                             '{1'b1, 16'h001E, 8'h04, 8'h81, 16'h0000, 8'h20},
                             '{1'b1, 16'h0040, 8'h03, 8'h10, 16'h0040, 8'h04},
                             '{1'b1, 16'h0041, 8'h01, 8'h77, 16'h0040, 8'h04}};

    spc_if link();
    spc_if link2();

    spc_host i_spc_host (.link(link), .clk_sys_i(clk), .rstn_i(rstn), .req_valid_i(vld), .req_ready_o(rdy),
        .req_cmd_i(cmd), .req_addr_i(addr), .req_len_i(len), .wdata_i(wdat), .wdata_take_o(take),
        .rdata_o(rdat), .rdata_valid_o(rval));
    spc_device #(.COMMIT_CYCLES(COMMIT)) i_spc_device (.link(link), .clk_sys_i(clk), .rstn_i(rstn),
        .memory_space_select_i(ees), .ee_busy_o(busy));
    spc_device #(.COMMIT_CYCLES(COMMIT)) i_spc_device_2 (.link(link2), .clk_sys_i(clk), .rstn_i(rstn),
        .memory_space_select_i(ees), .ee_busy_o(busy2));
    spc_assertions #(.COMMIT(COMMIT)) i_spc_assertions (.clk_sys_i(clk), .rstn_i(rstn), .sclk(link.sclk),
        .chip_select_low(link.chip_select_low), .mosi(link.mosi), .mosi_oe(link.mosi_oe), .miso(link.miso),
        .miso_oe(link.miso_oe), .ee_busy_o(busy));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ====================
    // host user side: collect read bytes, feed write bytes
    always @(posedge clk)
    begin
        #1;
        if (rval === 1'b1)
            rq.push_back(rdat);
        if (take === 1'b1)
        begin
            wdat = (wi + 1 < wq.size()) ? wq[wi + 1] : 8'h00;
            wi = wi + 1;
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic xfer(input logic [7:0] c, input logic [15:0] a, input logic [7:0] n);
        int t;
        t = 0;
        @(posedge clk) #1;
        rq.delete();
        wi = 0;
        wdat = (wq.size() > 0) ? wq[0] : 8'h00;
        cmd = c;
        addr = a;
        len = n;
        vld = 1'b1;
        @(posedge clk) #1;
        vld = 1'b0;
        while (rdy !== 1'b1 && t < 5000)
        begin
            @(posedge clk) #1;
            t++;
        end
        if (t >= 5000)
            miscompares++;
    endtask

    task automatic rd(input logic e, input logic [15:0] a, input logic [7:0] n);
        xfer(SPC_CMD_READ, a, n);
        for (int i = 0; i < n; i++)
            chk("read data", rq[i], e ? eem[8'(a + i)] : regm[6'(a + i)]);
    endtask

    task automatic wr(input logic e, input logic [15:0] a, input logic [7:0] n, input logic [7:0] b);
        int t;
        wq.delete();
        for (int i = 0; i < n; i++)
        begin
            wq.push_back(b + 8'(i));
            if (e)
                eem[{a[7:5], 5'(a[4:0] + i)}] = b + 8'(i);
            else
                regm[6'(a + i)] = b + 8'(i);
        end
        if (e)
            xfer(SPC_CMD_WREN, 16'h0000, 8'h00);
        xfer(SPC_CMD_WRITE, a, n);
        if (e)
        begin
            xfer(SPC_CMD_RDSR, 16'h0000, 8'h01);
            chk("status busy", rq[0] & 8'h01, 8'h01);
            t = 0;
            while (busy !== 1'b0 && t < 1000)
            begin
                @(posedge clk) #1;
                t++;
            end
            if (t >= 1000)
                miscompares++;
            xfer(SPC_CMD_RDSR, 16'h0000, 8'h01);
            chk("status idle", rq[0] & 8'h01, 8'h00);
        end
    endtask

    // hand-driven frame on the second link, bench-made clock
    task automatic bb(input logic [63:0] v, input int n);
        #2;
        link2.chip_select_low = 1'b0;
        link2.mosi_oe = 1'b1;
        for (int k = n - 1; k >= 0; k--)
        begin
            link2.mosi = v[k];
            #24 link2.sclk = 1'b1;
            rx = {rx[62:0], link2.miso};
            #24 link2.sclk = 1'b0;
        end
        #24 link2.chip_select_low = 1'b1;
        link2.mosi_oe = 1'b0;
        link2.mosi = ~link2.mosi;
        repeat (4)
        begin
            #24 link2.sclk = 1'b1;
            #24 link2.sclk = 1'b0;
        end
    endtask

    initial
    begin
        #400000;
        miscompares++;
        print_verdict();
    end

    // ====================
    // main sequence
    initial
    begin
        {rstn, ees, vld, cmd, addr, len, wdat, wi, checked, miscompares, rx} = '0;
        {link2.sclk, link2.mosi, link2.mosi_oe} = 3'h0;
        link2.chip_select_low = 1'b1;
        foreach (regm[i]) regm[i] = 8'h00;
        foreach (eem[i]) eem[i] = 8'h00;
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        chk("ready after reset", {7'h00, rdy}, 8'h01);
        foreach (rows[i])
        begin
            ees = rows[i].ees;
            wr(rows[i].ees, rows[i].wa, rows[i].wl, rows[i].base);
            rd(rows[i].ees, rows[i].ra, rows[i].rl);
        end
        // latch was cleared by the last eeprom write data byte
        wq = '{8'hEE};
        xfer(SPC_CMD_WRITE, 16'h0080, 8'h01);
        repeat (20) @(posedge clk);
        chk("busy without latch", {7'h00, busy}, 8'h00);
        rd(1'b1, 16'h0080, 8'h01);
        xfer(8'h9F, 16'h0005, 8'h01);
        ees = 1'b0;
        bb({28'h0, SPC_CMD_WRITE, 16'h0005, 8'h5A, 4'hF}, 36);
        bb({52'h0, SPC_CMD_READ, 4'h0}, 12);
        bb({24'h0, SPC_CMD_READ, 16'h0005, 16'h0000}, 40);
        chk("full byte", rx[15:8], 8'h5A);
        chk("partial byte", rx[7:0], 8'h00);
        ees = 1'b1;
        bb({56'h0, SPC_CMD_WREN}, 8);
        bb({29'h0, SPC_CMD_WRITE, 16'h0010, 8'hC3, 3'h5}, 35);
        repeat (20) @(posedge clk);
        chk("busy after abort", {7'h00, busy2}, 8'h00);
        bb({32'h0, SPC_CMD_READ, 16'h0010, 8'h00}, 32);
        chk("page after abort", rx[7:0], 8'h00);
        bb({56'h0, SPC_CMD_WREN}, 8);
        bb({32'h0, SPC_CMD_WRITE, 16'h0010, 8'hC3}, 32);
        repeat (20) @(posedge clk) #1;
        chk("busy after idle clocks", {7'h00, busy2}, 8'h01);
        // reset in the middle of a read data byte
        fork
            xfer(SPC_CMD_READ, 16'h003E, 8'h02);
            begin
                repeat (220) @(posedge clk);
                #1 rstn = 1'b0;
                repeat (2) @(posedge clk);
                chk("select in reset", {7'h00, link.chip_select_low}, 8'h01);
                chk("miso enable in reset", {7'h00, link.miso_oe}, 8'h00);
                #1 rstn = 1'b1;
            end
        join
        foreach (regm[i]) regm[i] = 8'h00;
        ees = 1'b0;
        rd(1'b0, 16'h003E, 8'h02);
        print_verdict();
    end
endmodule
